//--- src/alarm_defines.svh
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// ************************************************************
// fault and warning codes, two characters each
// ************************************************************
`define CODE_NONE 8'h00
`define CODE_PARAM 8'h04
`define CODE_OVERCUR 8'h10
`define CODE_REGEN_ERR 8'h30
`define CODE_REGEN_OVL 8'h32
`define CODE_VOLTAGE 8'h40
`define CODE_OVERSPEED 8'h51
`define CODE_OVERLOAD 8'h70
`define CODE_DB_OVL 8'h73
`define CODE_INRUSH 8'h74
`define CODE_OVERHEAT 8'h7A
`define CODE_SYSTEM 8'hBF
`define CODE_RUNAWAY 8'hC1
`define CODE_PHASE 8'hC2
`define CODE_ENC_DISC 8'hC3
`define CODE_DEV_OVF 8'hD0
`define CODE_WARN_OVL 8'h91
`define CODE_WARN_REGEN 8'h92
`define CODE_TERM_NOLINK 8'h00
`define CODE_TERM_TIMEOUT 8'h01

// ************************************************************
// display character codes and timing, torque limit and deviation width
// ************************************************************
`define CHAR_A 5'h0A
`define CHAR_DOT 5'h10
`define CHAR_BLANK 5'h11
`define DISP_STEP_MS 500
`define CLOCK_KHZ 25000
`define DISP_STEP_CYCLES (`DISP_STEP_MS * `CLOCK_KHZ)
`define TORQUE_LIMIT_PCT 120
`define DEV_WIDTH 32

`endif

//--- src/alarm_pkg.sv
package alarm_pkg;
   `include "alarm_defines.svh"

   typedef struct packed {
      logic param_mismatch;
      logic overcurrent;
      logic heatsink_rise;
      logic regen_damaged;
      logic regen_excess;
      logic bus_out_of_window;
      logic overspeed;
      logic db_excess;
      logic inrush_excess;
      logic control_fail;
      logic reverse_motion;
      logic angle_error;
      logic enc_open;
      logic regen_near;
      logic [15:0] torque_pct;
      logic [15:0] overload_warn_pct;
   } detect_t;

   typedef struct packed {
      logic clear_input;
      logic key_clear;
      logic run_cmd;
   } host_t;

   typedef enum logic [1:0] {
      st_normal,
      st_fault
   } sup_state_t;
endpackage

//--- src/code_display.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_defines.svh"
module code_display
   import alarm_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `DISP_STEP_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic show,
   input wire logic [7:0] code,
   output logic [4:0] char_reg
);
   logic [31:0] tick_reg;
   logic [1:0] pos_reg;

   // ************************************************************
   // step timer and position
   // ************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tick_reg <= 32'h0;
         pos_reg <= 2'h0;
      end else if (enable) begin
         if (!show) begin
            tick_reg <= 32'h0;
            pos_reg <= 2'h0;
         end else if (tick_reg >= STEP_CYCLES - 1) begin
            tick_reg <= 32'h0;
            pos_reg <= (pos_reg == 2'h3) ? 2'h0 : pos_reg + 2'h1;
         end else begin
            tick_reg <= tick_reg + 32'h1;
         end
      end
   end

   // one character at a time: A, dot, high digit, low digit
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         char_reg <= `CHAR_BLANK;
      end else if (enable) begin
         if (!show) begin
            char_reg <= `CHAR_BLANK;
         end else begin
            case (pos_reg)
               2'h0: char_reg <= `CHAR_A;
               2'h1: char_reg <= `CHAR_DOT;
               2'h2: char_reg <= {1'b0, code[7:4]};
               2'h3: char_reg <= {1'b0, code[3:0]};
               default: char_reg <= `CHAR_BLANK;
            endcase
         end
      end
   end

   seq_walk_a: assert property (@(posedge clock) disable iff (!rst_b)
      (enable && show && pos_reg == 2'h0 && $past(enable)) |=> char_reg == `CHAR_A)
      else $error("display does not show the lead character");
endmodule
`default_nettype wire

//--- src/servo_alarm_manager.sv
// What this block does
// - fault drops output, disables drive, shows code
// - warning shows code, drive keeps running
// - clear by input, power cycle, or keys
// - some faults clear only by power cycle
// - run still active restarts drive after clear
// - code shown one character at a time
// - motor mismatch raises parameter fault
// - overcurrent or heatsink rise raises overcurrent
// - damaged regen circuit raises regen error
// - excess regen energy raises regen overload
// - bus voltage out of window faults
// - speed above maximum raises overspeed
// - torque above 120 percent raises overload
// - brake energy excess raises brake overload
// - inrush excess raises inrush overload
// - heatsink overheat and control failure fault
// - reverse motion raises runaway fault
// - angle error and encoder open fault
// - deviation above threshold raises overflow fault
// - warnings precede overload and regen faults
// - terminal link failures only on terminal
`timescale 1ns/1ps
`default_nettype none
`include "alarm_defines.svh"
module servo_alarm_manager
   import alarm_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `DISP_STEP_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clock_en,
   input wire alarm_pkg::detect_t detect,
   input wire alarm_pkg::host_t host,
   input wire logic [15:0] speed_abs,
   input wire logic [15:0] speed_max,
   input wire logic [`DEV_WIDTH-1:0] deviation_abs,
   input wire logic [`DEV_WIDTH-1:0] overflow_threshold_setting,
   input wire logic term_no_link,
   input wire logic term_timeout,
   output logic fault_output_b,
   output logic drive_enable,
   output logic [7:0] active_code,
   output logic code_is_warning,
   output logic [4:0] display_char,
   output logic [7:0] terminal_code,
   output logic terminal_error
);
   import alarm_pkg::*;

   sup_state_t state_reg;
   logic [7:0] fault_code_reg;
   logic [7:0] detect_code;
   logic [7:0] warn_code;
   logic clear_ok;
   logic show_code;

   // ************************************************************
   // fault priority encode
   // ************************************************************
   function automatic logic [7:0] pick_fault(input detect_t d, input logic ovs, input logic dev);
      logic [7:0] c;
      c = `CODE_NONE;
      if (d.control_fail) c = `CODE_SYSTEM;
      else if (d.param_mismatch) c = `CODE_PARAM;
      else if (d.overcurrent || d.heatsink_rise) c = `CODE_OVERCUR;
      else if (d.enc_open) c = `CODE_ENC_DISC;
      else if (d.angle_error) c = `CODE_PHASE;
      else if (d.regen_damaged) c = `CODE_REGEN_ERR;
      else if (d.regen_excess) c = `CODE_REGEN_OVL;
      else if (d.bus_out_of_window) c = `CODE_VOLTAGE;
      else if (d.overspeed || ovs) c = `CODE_OVERSPEED;
      else if (d.torque_pct > 16'(`TORQUE_LIMIT_PCT)) c = `CODE_OVERLOAD;
      else if (d.db_excess) c = `CODE_DB_OVL;
      else if (d.inrush_excess) c = `CODE_INRUSH;
      else if (d.heatsink_rise) c = `CODE_OVERHEAT;
      else if (d.reverse_motion) c = `CODE_RUNAWAY;
      else if (dev) c = `CODE_DEV_OVF;
      return c;
   endfunction

   // power-cycle-only codes ignore clear input and keys
   function automatic logic power_cycle_only(input logic [7:0] c);
      return c == `CODE_PARAM || c == `CODE_OVERCUR || c == `CODE_SYSTEM ||
             c == `CODE_PHASE || c == `CODE_ENC_DISC;
   endfunction

   assign detect_code = pick_fault(detect, speed_abs > speed_max,
                                   deviation_abs > overflow_threshold_setting);

   // warning threshold sits below the fault threshold
   always_comb begin
      warn_code = `CODE_NONE;
      if (detect.torque_pct > detect.overload_warn_pct) warn_code = `CODE_WARN_OVL;
      else if (detect.regen_near) warn_code = `CODE_WARN_REGEN;
   end

   assign clear_ok = (host.clear_input || host.key_clear) &&
                     !power_cycle_only(fault_code_reg);

   // ************************************************************
   // fault latch
   // ************************************************************
   // a fault still present in the clearing cycle blocks the clear, so the latch keeps its code and set wins over clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= st_normal; // power cycle clears everything
         fault_code_reg <= `CODE_NONE;
      end else if (clock_en) begin
         case (state_reg)
            st_normal: begin
               if (detect_code != `CODE_NONE) begin
                  state_reg <= st_fault;
                  fault_code_reg <= detect_code;
               end
            end
            st_fault: begin
               if (clear_ok && detect_code == `CODE_NONE) begin
                  state_reg <= st_normal;
                  fault_code_reg <= `CODE_NONE;
               end
            end
            default: begin
               state_reg <= st_normal;
               fault_code_reg <= `CODE_NONE;
            end
         endcase
      end
   end

   // ************************************************************
   // fault output and drive
   // ************************************************************
   // no run interlock on clear: the host must drop run first
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fault_output_b <= 1'b0;
         drive_enable <= 1'b0;
      end else if (clock_en) begin
         fault_output_b <= (state_reg == st_normal) && (detect_code == `CODE_NONE);
         drive_enable <= (state_reg == st_normal) && (detect_code == `CODE_NONE)
                         && host.run_cmd;
      end
   end

   // ************************************************************
   // code reporting
   // ************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         active_code <= `CODE_NONE;
         code_is_warning <= 1'b0;
      end else if (clock_en) begin
         if (state_reg == st_fault) begin
            active_code <= fault_code_reg;
            code_is_warning <= 1'b0;
         end else begin
            active_code <= warn_code;
            code_is_warning <= warn_code != `CODE_NONE;
         end
      end
   end

   // terminal link faults never reach the front panel
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         terminal_code <= `CODE_NONE;
         terminal_error <= 1'b0;
      end else if (clock_en) begin
         terminal_error <= term_no_link || term_timeout;
         terminal_code <= term_no_link ? `CODE_TERM_NOLINK :
                          term_timeout ? `CODE_TERM_TIMEOUT : `CODE_NONE;
      end
   end

   assign show_code = (state_reg == st_fault) || (warn_code != `CODE_NONE);

   code_display #(.STEP_CYCLES(STEP_CYCLES)) u_display (
      .clock(clock),
      .rst_b(rst_b),
      .enable(clock_en),
      .show(show_code),
      .code((state_reg == st_fault) ? fault_code_reg : warn_code),
      .char_reg(display_char)
   );

   // ************************************************************
   // checks
   // ************************************************************
   sequence fault_held;
      state_reg == st_fault;
   endsequence

   // a clear that the latch accepts: allowed code, detection already gone
   sequence clear_taken;
      (clock_en && clear_ok && detect_code == `CODE_NONE) and fault_held;
   endsequence

   sequence new_fault;
      clock_en && state_reg == st_normal && detect_code != `CODE_NONE;
   endsequence

   drive_off_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en and fault_held) |=> (!drive_enable && !fault_output_b))
      else $error("drive stays on during a fault");

   latch_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      ((clock_en && !(host.clear_input || host.key_clear)) and fault_held) |=> fault_held)
      else $error("fault released without a clear");

   power_only_a: assert property (@(posedge clock) disable iff (!rst_b)
      ((clock_en && power_cycle_only(fault_code_reg)) and fault_held) |=> fault_held)
      else $error("power cycle fault released by clear");

   warn_run_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && detect_code == `CODE_NONE && host.run_cmd)
      |=> (drive_enable && fault_output_b))
      else $error("warning stopped the drive");

   restart_a: assert property (@(posedge clock) disable iff (!rst_b)
      clear_taken
      ##1 (clock_en && detect_code == `CODE_NONE && host.run_cmd) |=> drive_enable)
      else $error("drive not re-enabled after clear");

   overload_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && detect_code == `CODE_OVERLOAD)
      |=> fault_code_reg == `CODE_OVERLOAD)
      else $error("overload code not latched");

   dev_ovf_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && deviation_abs > overflow_threshold_setting)
      |=> fault_held)
      else $error("deviation overflow missed");

   term_only_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && term_timeout && state_reg == st_normal && warn_code == `CODE_NONE)
      |=> (terminal_error && active_code == `CODE_NONE))
      else $error("terminal error leaked to panel");

   fault_now_a: assert property (@(posedge clock) disable iff (!rst_b)
      new_fault |=> (!fault_output_b && !drive_enable))
      else $error("fault output not dropped on detection");

   first_code_a: assert property (@(posedge clock) disable iff (!rst_b)
      new_fault |=> (state_reg == st_fault && fault_code_reg == $past(detect_code)))
      else $error("detected code not latched");

   code_kept_a: assert property (@(posedge clock) disable iff (!rst_b)
      ((clock_en && !clear_ok) and fault_held) |=> $stable(fault_code_reg))
      else $error("latched code changed without a clear");

   refuse_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      ((clock_en && detect_code != `CODE_NONE) and fault_held) |=> fault_held)
      else $error("clear taken while detection present");

   fault_shown_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en and fault_held) |=> (active_code == $past(fault_code_reg) && !code_is_warning))
      else $error("latched code not reported");

   warn_shown_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && warn_code != `CODE_NONE)
      |=> (active_code == $past(warn_code) && code_is_warning))
      else $error("warning code not reported");

   run_off_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && !host.run_cmd) |=> !drive_enable)
      else $error("drive on without run command");

   state_freeze_a: assert property (@(posedge clock) disable iff (!rst_b)
      !clock_en |=> ($stable(state_reg) && $stable(fault_code_reg)
         && $stable(fault_output_b) && $stable(drive_enable)))
      else $error("state moved while clock enable low");

   term_link_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && term_no_link) |=> (terminal_error && terminal_code == `CODE_TERM_NOLINK))
      else $error("terminal link loss not reported");

   system_code_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && detect.control_fail) |=> fault_code_reg == `CODE_SYSTEM)
      else $error("system error code not latched");

   param_code_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && detect.param_mismatch && !detect.control_fail)
      |=> fault_code_reg == `CODE_PARAM)
      else $error("parameter fault code not latched");

   overspeed_hit_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && speed_abs > speed_max) |=> fault_held)
      else $error("overspeed missed");

   overcur_hit_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && (detect.overcurrent || detect.heatsink_rise))
      |=> fault_held)
      else $error("overcurrent missed");

   regen_hit_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && (detect.regen_damaged || detect.regen_excess))
      |=> fault_held)
      else $error("regeneration fault missed");

   brake_hit_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && detect.db_excess) |=> fault_held)
      else $error("brake overload missed");

   inrush_hit_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clock_en && state_reg == st_normal && detect.inrush_excess) |=> fault_held)
      else $error("inrush overload missed");
endmodule
`default_nettype wire

//--- verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// host controller model
// ********************
module host_model
   import alarm_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic run_req,
   input wire logic clear_req,
   input wire logic key_req,
   input wire logic polite,
   output var alarm_pkg::host_t host
);
   // a polite host drops run one cycle before asking for a clear,
   // an impolite one keeps run up so the restart path gets exercised
   always_ff @(negedge clock or negedge rst_b) begin
      if (!rst_b) begin
         host <= '0;
      end else begin
         host.run_cmd <= run_req & ~(polite & (clear_req | key_req));
         host.clear_input <= clear_req & ~(polite & host.run_cmd);
         host.key_clear <= key_req & ~(polite & host.run_cmd);
      end
   end
endmodule
`default_nettype wire

//--- verification/test_servo_alarm_manager.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_defines.svh"
module test_servo_alarm_manager;
   import alarm_pkg::*;
   localparam int STEP = 4;
   logic clock, rst_b, clock_en, run_req, clear_req, key_req, polite;
   detect_t detect;
   host_t host;
   logic [15:0] speed_abs, speed_max;
   logic [`DEV_WIDTH-1:0] deviation_abs, threshold;
   logic term_no_link, term_timeout, fault_output_b, drive_enable;
   logic code_is_warning, terminal_error;
   logic [7:0] active_code, terminal_code;
   logic [4:0] display_char;
   logic [4:0] seq [$];
   int num_errors, samples_checked, seed;

   host_model i_host (.clock(clock), .rst_b(rst_b), .run_req(run_req), .clear_req(clear_req),
      .key_req(key_req), .polite(polite), .host(host));
   servo_alarm_manager #(.STEP_CYCLES(STEP)) i_dut (.clock(clock), .rst_b(rst_b),
      .clock_en(clock_en), .detect(detect), .host(host), .speed_abs(speed_abs),
      .speed_max(speed_max), .deviation_abs(deviation_abs),
      .overflow_threshold_setting(threshold), .term_no_link(term_no_link),
      .term_timeout(term_timeout), .fault_output_b(fault_output_b),
      .drive_enable(drive_enable), .active_code(active_code),
      .code_is_warning(code_is_warning), .display_char(display_char),
      .terminal_code(terminal_code), .terminal_error(terminal_error));

   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end

   // ********************
   // checking helpers
   // ********************
   task automatic chk_c(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: code %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_f(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   function automatic logic [7:0] code_of(input int k);
      logic [7:0] t [0:14];
      t = '{8'h04, 8'h10, 8'h10, 8'h30, 8'h32, 8'h40, 8'h51, 8'h70, 8'h73, 8'h74, 8'hBF,
         8'hC1, 8'hC2, 8'hC3, 8'hD0};
      return t[k];
   endfunction

   function automatic logic pc_only(input logic [7:0] c);
      return c inside {8'h04, 8'h10, 8'hBF, 8'hC2, 8'hC3};
   endfunction

   // ********************
   // stimulus helpers
   // ********************
   // counts sit exactly on their limits so an off-by-one compare faults
   task automatic quiet;
      detect = '0;
      detect.torque_pct = 16'h32 + 16'({$random(seed)} % 40);
      detect.overload_warn_pct = 16'h64;
      speed_max = 16'h3E8 + 16'({$random(seed)} % 5000);
      speed_abs = speed_max;
      threshold = 32'h1 + 32'({$random(seed)} % 100000);
      deviation_abs = threshold;
      term_no_link = 1'h0;
      term_timeout = 1'h0;
   endtask

   task automatic pwr;
      rst_b <= 1'h0;
      cyc(1);
      chk_f(fault_output_b, 1'h0);
      chk_c({3'h0, display_char}, {3'h0, `CHAR_BLANK});
      cyc(3);
      rst_b <= 1'h1;
      cyc(1);
   endtask

   task automatic fire(input int k);
      case (k)
         0: detect.param_mismatch = 1'h1;
         1: detect.overcurrent = 1'h1;
         2: detect.heatsink_rise = 1'h1;
         3: detect.regen_damaged = 1'h1;
         4: detect.regen_excess = 1'h1;
         5: detect.bus_out_of_window = 1'h1;
         6: speed_abs = speed_max + 16'h1;
         7: detect.torque_pct = 16'h79;
         8: detect.db_excess = 1'h1;
         9: detect.inrush_excess = 1'h1;
         10: detect.control_fail = 1'h1;
         11: detect.reverse_motion = 1'h1;
         12: detect.angle_error = 1'h1;
         13: detect.enc_open = 1'h1;
         default: deviation_abs = threshold + 32'h1;
      endcase
   endtask

   task automatic wait_fault;
      for (int i = 0; i < 10 && fault_output_b !== 1'h0; i++) cyc(1);
      if (fault_output_b !== 1'h0) begin
         num_errors++;
         $display("Error at %0t: fault never reported", $time);
         report_and_stop();
      end
   endtask

   task automatic do_clear(input logic via_key, input logic pol);
      polite <= pol;
      clear_req <= ~via_key;
      key_req <= via_key;
      cyc(4);
      clear_req <= 1'h0;
      key_req <= 1'h0;
      cyc(3);
   endtask

   task automatic run_fault(input int k, input logic via_key, input logic pol);
      logic [7:0] c;
      c = code_of(k);
      quiet();
      run_req <= 1'h1;
      cyc(2);
      fire(k);
      wait_fault();
      cyc(2);
      chk_f(drive_enable, 1'h0);
      chk_c(active_code, c);
      quiet();
      do_clear(via_key, pol);
      if (pc_only(c)) begin
         chk_f(fault_output_b, 1'h0);
         chk_c(active_code, c);
         pwr();
      end else begin
         chk_f(drive_enable, 1'h1);
      end
      chk_f(fault_output_b, 1'h1);
      chk_c(active_code, 8'h00);
   endtask

   // ********************
   // main sequence
   // ********************
   initial begin
      logic [4:0] e [0:3];
      int i;
      seed = 32'h940C;
      num_errors = 0;
      samples_checked = 0;
      clock_en = 1'h1;
      run_req = 1'h0;
      clear_req = 1'h0;
      key_req = 1'h0;
      polite = 1'h1;
      quiet();
      pwr();
      chk_f(fault_output_b, 1'h1);
      for (int k = 0; k < 15; k++) run_fault(k, k[0], k[1]);
      repeat (8) run_fault({$random(seed)} % 15, 1'($random(seed)), 1'($random(seed)));
      // warnings: torque at 120 warns but must not fault
      for (int j = 0; j < 2; j++) begin
         quiet();
         if (j == 0) detect.torque_pct = 16'h78;
         else detect.regen_near = 1'h1;
         cyc(3);
         chk_c(active_code, (j == 0) ? 8'h91 : 8'h92);
         chk_f(code_is_warning, 1'h1);
         chk_f(fault_output_b, 1'h1);
         chk_f(drive_enable, 1'h1);
      end
      for (int j = 0; j < 2; j++) begin
         quiet();
         term_no_link = (j == 0);
         term_timeout = (j == 1);
         cyc(3);
         chk_c(terminal_code, 8'(j));
         chk_f(terminal_error, 1'h1);
         chk_c(active_code, 8'h00);
         chk_c({3'h0, display_char}, {3'h0, `CHAR_BLANK});
      end
      quiet();
      // a frozen block must not latch the detection until enable returns
      clock_en = 1'h0;
      fire(14);
      cyc(3);
      chk_f(fault_output_b, 1'h1);
      clock_en = 1'h1;
      wait_fault();
      fire(6);
      cyc(3);
      chk_c(active_code, 8'hD0);
      quiet();
      cyc(5);
      chk_f(fault_output_b, 1'h0);
      do_clear(1'h0, 1'h1);
      fire(13);
      wait_fault();
      seq = {};
      repeat (40) begin
         cyc(1);
         if (seq.size() == 0 || seq[$] !== display_char) seq.push_back(display_char);
      end
      e = '{`CHAR_A, `CHAR_DOT, 5'h0C, 5'h03};
      for (i = 0; i + 4 < seq.size() && seq[i] !== `CHAR_A; i++);
      for (int j = 0; j < 4; j++) chk_c({3'h0, seq[i + j]}, {3'h0, e[j]});
      pwr();
      report_and_stop();
   end
endmodule
`default_nettype wire
